/* bench/sasp_link_props.sv */
// assertions on the link wires joining the host end and the device end
// assumes both ends run on mclk_in and the host half period is HALF_DIV
`timescale 1ns/1ps
module sasp_link_props #(
    parameter int HALF_DIV = 6
)
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // link wires
    input wire logic bit_clock,
    input wire logic word_clock,
    input wire logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic sdo_en_b
);
    // ========================================
    // edge history and run lengths; counters keep the repetitions short
    logic bck_r;
    logic wck_r;
    logic [15:0] hi_r;
    logic [15:0] lo_r;
    logic [7:0] fall_r;
    logic [7:0] rise_r;
    logic [1:0] chg_r;
    wire rise_w = bit_clock & ~bck_r;
    wire fall_w = ~bit_clock & bck_r;
    wire wchg_w = word_clock ^ wck_r;
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            bck_r <= 1'b0;
            wck_r <= 1'b0;
            hi_r <= 16'h0000;
            lo_r <= 16'h0000;
            fall_r <= 8'h00;
            rise_r <= 8'h00;
            chg_r <= 2'h0;
        end
        else
        begin
            bck_r <= bit_clock;
            wck_r <= word_clock;
            hi_r <= bit_clock ? hi_r + 16'h0001 : 16'h0000;
            lo_r <= bit_clock ? 16'h0000 : lo_r + 16'h0001;
            fall_r <= fall_w ? 8'h01 : fall_r + {7'h00, fall_r != 8'hFF};
            rise_r <= wchg_w ? 8'h00 : rise_r + {7'h00, rise_w};
            chg_r <= chg_r + {1'b0, wchg_w && chg_r != 2'h3};
        end
    end
    // ========================================
    // the low time and slot length checks skip the first frames after reset: the host may misplace them
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    sequence bck_fall_s;
        fall_w;
    endsequence
    sequence held_s;
        ($stable(word_clock) && $stable(serial_data_in)) [*4];
    endsequence
    clk_high_a: assert property (bck_fall_s |-> hi_r == HALF_DIV)
        else $error("bit clock high time wrong");
    clk_low_a: assert property (rise_w && chg_r != 2'h0 |-> lo_r == HALF_DIV)
        else $error("bit clock low time wrong");
    wclk_edge_a: assert property ($changed(word_clock) |-> !bit_clock)
        else $error("word clock moved while bit clock high");
    sdin_edge_a: assert property ($changed(serial_data_in) |-> !bit_clock)
        else $error("data input moved while bit clock high");
    hold_time_a: assert property (rise_w |-> held_s)
        else $error("link inputs not held after rise");
    sdo_hold_a: assert property ($changed(serial_data_out) && !sdo_en_b |-> !bit_clock)
        else $error("data output moved while bit clock high");
    sdo_delay_a: assert property ($changed(serial_data_out) |-> fall_r <= 8'h05)
        else $error("data output late after fall");
    frame_len_a: assert property (wchg_w && chg_r == 2'h3 |->
        rise_r inside {8'h01, 8'h10, 8'h18, 8'h20, 8'h3F, 8'h5F, 8'h7F})
        else $error("slot length of word clock wrong");
endmodule : sasp_link_props

/* bench/slave_audio_serial_port_test.sv */
// bench: host end and device end joined over the link, table driven
// assumes the design files and sasp_link_props are compiled before it
`include "sasp_map.svh"
`timescale 1ns/1ps
module slave_audio_serial_port_test;
    // ========================================
    // stimulus and observed signals
    typedef struct packed {logic [1:0] f, w, s; logic t, a; logic [1:0] c;} sasp_row_type;
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    sasp_row_type x = 10'h000;
    logic [31:0] hl = 32'hC3A5_96E1;
    logic [31:0] hr = 32'h1E5A_7B3D;
    logic [31:0] dl = 32'h6B2D_F0A7;
    logic [31:0] dr = 32'hA4F1_3C59;
    wire hready;
    wire [31:0] hrdata, sample, rxl, rxr;
    int num_errors = 0;
    int check_count = 0;
    // rows: format, width, slot length, tdm, attenuate, source
    sasp_row_type rows [6] = '{10'h000, 10'h151, 10'h2A6, 10'h0EA, 10'h11C, 10'h221};
    sasp_link_if link ();
    always #5 mclk_in = ~mclk_in;
    // ========================================
    // both ends and the wire checker
    sasp_device u_sasp_device (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .link(link),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready),
        .hrdata_out(hrdata), .hresp_out(), .sample_out(sample), .sample_valid_out(),
        .pll_ref_out());
    sasp_host #(.HALF_DIV(6)) u_sasp_host (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
        .link(link), .enable_in(1'b1), .format_in(x.f), .width_sel_in(x.w),
        .slot_len_sel_in(x.s), .tdm_in(x.t), .tx_left_in(hl), .tx_right_in(hr),
        .rx_left_out(rxl), .rx_right_out(rxr), .rx_valid_out());
    sasp_link_props #(.HALF_DIV(6)) u_sasp_link_props (.mclk_in(mclk_in),
        .rst_b_in(rst_b_in), .bit_clock(link.bit_clock), .word_clock(link.word_clock),
        .serial_data_in(link.serial_data_in), .serial_data_out(link.serial_data_out),
        .sdo_en_b(link.sdo_en_b));
    // ========================================
    // verdict, comparison and hang handling
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] e, input logic [31:0] a);
        check_count++;
        if (a !== e)
        begin
            num_errors++;
            $display("MISMATCH at %0t exp %h got %h", $time, e, a);
        end
    endtask : chk
    // bus waits look at hready on the falling edge, before it is sampled
    task automatic rdy(output logic [31:0] d);
        int n;
        n = 0;
        @(negedge mclk_in);
        while (hready !== 1'b1 && n < 99)
        begin
            n++;
            @(negedge mclk_in);
        end
        if (n == 99)
        begin
            num_errors++;
            report_and_stop();
        end
        d = hrdata;
        @(posedge mclk_in);
    endtask : rdy
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        rdy(rd);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        rdy(rd);
    endtask : ahb
    // counts host word strobes; a pulse lasts one cycle, so every cycle is seen
    task automatic frames(input int k);
        int n;
        n = 0;
        while (k > 0 && n < 20000)
        begin
            @(negedge mclk_in);
            n++;
            if (u_sasp_host.rx_valid_out === 1'b1)
                k--;
        end
        if (k > 0)
        begin
            num_errors++;
            report_and_stop();
        end
        @(posedge mclk_in);
    endtask : frames
    task automatic watch(output int hi, output int lo);
        hi = 0;
        lo = 0;
        repeat (1600)
        begin
            @(negedge mclk_in);
            if (link.sdo_en_b === 1'b1)
                hi++;
            else
                lo++;
        end
        @(posedge mclk_in);
    endtask : watch
    task automatic do_reset();
        rst_b_in <= 1'b0;
        repeat (20) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        @(posedge mclk_in);
    endtask : do_reset
    // ========================================
    // expectations: msb aligned words cut to width, then source and level
    function automatic logic [31:0] msk(input logic [31:0] v);
        int b;
        b = (x.w == 2'h0) ? 16 : (x.w == 2'h1) ? 20 : (x.w == 2'h2) ? 24 : 32;
        return v & ~(32'hFFFF_FFFF >> b);
    endfunction : msk
    function automatic logic [31:0] mix(input logic [31:0] l, input logic [31:0] g);
        logic signed [32:0] s;
        s = (x.c == 2'h0) ? $signed({l[31], l}) : (x.c == 2'h1) ? $signed({g[31], g}) :
            ($signed({l[31], l}) + $signed({g[31], g})) >>> 1;
        if (x.a)
            s = s >>> 1;
        return s[31:0];
    endfunction : mix
    // ========================================
    // table rows first, then reset values, unmapped place and pin control
    initial
    begin
        logic [31:0] d;
        logic [31:0] c;
        int hi;
        int lo;
        foreach (rows[i])
        begin
            x <= rows[i];
            do_reset();
            c = {18'h0_0000, x.c, x.a, x.t, x.s, 4'(i), x.w, x.f};
            ahb(1'b1, `SASP_CTRL_OFS, c, d);
            ahb(1'b1, `SASP_CFG_OFS, 32'h0000_0001, d);
            ahb(1'b1, `SASP_TXL_OFS, dl, d);
            ahb(1'b1, `SASP_TXR_OFS, dr, d);
            frames(3);
            chk(msk(dl), rxl);
            chk(msk(dr), rxr);
            ahb(1'b0, `SASP_RXL_OFS, 32'h0000_0000, d);
            chk(msk(hl), d);
            ahb(1'b0, `SASP_RXR_OFS, 32'h0000_0000, d);
            chk(msk(hr), d);
            chk(mix(msk(hl), msk(hr)), sample);
            ahb(1'b0, `SASP_OUT_OFS, 32'h0000_0000, d);
            chk(mix(msk(hl), msk(hr)), d);
            ahb(1'b0, `SASP_CTRL_OFS, 32'h0000_0000, d);
            chk(c, d);
            $display("row %0d done", i);
        end
        x <= 10'h000;
        do_reset();
        ahb(1'b0, `SASP_CTRL_OFS, 32'h0000_0000, d);
        chk({18'h0_0000, `SASP_CTRL_RST}, d);
        ahb(1'b0, `SASP_CFG_OFS, 32'h0000_0000, d);
        chk({30'h0000_0000, `SASP_CFG_RST}, d);
        ahb(1'b1, 8'h20, 32'hFFFF_FFFF, d);
        ahb(1'b0, 8'h20, 32'h0000_0000, d);
        chk(32'h0000_0000, d);
        watch(hi, lo);
        chk(32'h0000_0000, lo);
        $display("reset and disable test done");
        x <= rows[3];
        do_reset();
        ahb(1'b1, `SASP_CTRL_OFS, 32'h0000_2E0C, d);
        ahb(1'b1, `SASP_CFG_OFS, 32'h0000_0001, d);
        frames(2);
        watch(hi, lo);
        chk(32'h0000_0000, hi);
        ahb(1'b1, `SASP_CFG_OFS, 32'h0000_0003, d);
        frames(2);
        watch(hi, lo);
        chk(32'h0000_0001, {31'h0000_0000, hi > 0 && lo > 0});
        $display("unused slot test done");
        report_and_stop();
    end
endmodule : slave_audio_serial_port_test

/* logic/sasp_device.sv */
// slave audio serial port, device end, with an ahb-lite register slave
// assumes the link clocks come from the far end and are far slower than mclk_in
//
// Summary of operation
// - clocks always come from the far end
// - full duplex over four dedicated link signals
// - two slots stereo, four slots time division
// - word width 16, 20, 24 or 32
// - three alignment formats, always msb first
// - word clock marks frame start, rate fs
// - sample rate field must match word clock
// - slot length 16, 24 or 32 clocks
// - far end clocks rate times length times slots
// - word clock 8-96 khz, bit clock 32-64 fs
// - 16 bit allows 32/48/64 fs, others 48/64
// - link clocks are timing and pll reference
// - attenuate control halves received audio
// - source is left, right or average
// - transmit enable gates data output pin
// - unused slots float or drive zeros
// - standard: low left, msb second rise
// - left aligned: high left, msb first rise
// - right aligned: lsb last rise before change
// - tdm frame pulse one slot or one bit
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`include "sasp_map.svh"
`timescale 1ns/1ps
module sasp_device
    import sasp_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // serial link
    sasp_link_if.dev link,
    // ahb-lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic [31:0] hrdata_out,
    output logic hresp_out,
    // downstream audio and pll reference
    output logic [31:0] sample_out,
    output logic sample_valid_out,
    output logic pll_ref_out
);
    // ==========================================================
    // registers
    logic [2:0] bck_q;
    logic [1:0] wck_q;
    logic [1:0] sdi_q;
    logic wck_prev_r;
    logic [5:0] pos_r;
    logic [1:0] slot_r;
    logic [31:0] sh_r;
    logic [31:0] rx_r [2];
    logic mix_go_r;
    logic [31:0] sample_r;
    logic sample_valid_r;
    logic pll_ref_r;
    logic sdo_r;
    logic sdo_en_b_r;
    logic [15:0] frames_r;
    logic [`SASP_CTRL_W-1:0] ctrl_r;
    logic [1:0] cfg_r;
    logic [31:0] tx_r [2];
    logic pend_r;
    logic wr_r;
    logic [7:0] addr_r;
    logic hreadyout_r;
    logic [31:0] hrdata_r;
    logic [31:0] rd_w;

    // ==========================================================
    // control decode
    wire [1:0] fmt_w = ctrl_r[`SASP_FMT_LSB +: 2];
    wire [5:0] wid_w = sasp_width(ctrl_r[`SASP_WID_LSB +: 2]);
    wire [5:0] slen_w = sasp_slen(ctrl_r[`SASP_SLEN_LSB +: 2]);
    wire tdm_w = ctrl_r[`SASP_TDM_BIT];
    wire att_w = ctrl_r[`SASP_ATT_BIT];
    wire [1:0] chs_w = ctrl_r[`SASP_CHS_LSB +: 2];
    wire std_w = fmt_w == SASP_FMT_STD;
    wire [1:0] last_slot_w = tdm_w ? 2'd3 : 2'd1;

    // ==========================================================
    // link edges; bit clock edges compare the second and third stages, the other inputs use the second
    wire bck_rise = bck_q[1] & ~bck_q[2];
    wire bck_fall = ~bck_q[1] & bck_q[2];
    wire wck_w = wck_q[1];
    wire sdi_w = sdi_q[1];

    // slot bookkeeping: a word clock change (only a rise in tdm) restarts the slot, else count
    wire wrap_w = pos_r == 6'(slen_w - 6'd1);
    wire [5:0] adv_pos = wrap_w ? 6'd0 : 6'(pos_r + 6'd1);
    wire [1:0] adv_slot = wrap_w ? ((slot_r == last_slot_w) ? 2'd0 : 2'(slot_r + 2'd1)) : slot_r;
    wire bound_w = tdm_w ? (wck_w & ~wck_prev_r) : (wck_w != wck_prev_r);
    wire chan_w = std_w ? wck_w : ~wck_w;
    wire [5:0] cur_pos = bound_w ? 6'd0 : adv_pos;
    wire [1:0] cur_slot = bound_w ? (tdm_w ? 2'd0 : {1'b0, chan_w}) : adv_slot;

    // standard format lags one bit clock, so it uses the previous position
    wire [5:0] rx_pos = std_w ? pos_r : cur_pos;
    wire [1:0] rx_slot = std_w ? slot_r : cur_slot;
    wire [6:0] rx_bp = sasp_bit_pos(fmt_w, wid_w, slen_w, rx_pos);
    wire rx_last = rx_bp[6] && (rx_bp[5:0] == 6'(wid_w - 6'd1));
    wire [31:0] rx_word = {sh_r[30:0], sdi_w} << 6'(6'd32 - wid_w);

    // the next rise is predicted at the fall; standard knows it exactly
    wire [5:0] tx_pos = std_w ? pos_r : adv_pos;
    wire [1:0] tx_slot = std_w ? slot_r : adv_slot;
    wire [6:0] tx_bp = sasp_bit_pos(fmt_w, wid_w, slen_w, tx_pos);
    wire tx_used = ~tx_slot[1];
    wire [31:0] tx_word = tx_r[tx_slot[0]];
    wire tx_bit = tx_bp[6] & tx_word[5'(5'd31 - tx_bp[4:0])];

    // mixing of the stored pair
    wire [32:0] sum_w = 33'({rx_r[0][31], rx_r[0]}) + 33'({rx_r[1][31], rx_r[1]});
    wire [31:0] src_w = (chs_w == SASP_CH_LEFT) ? rx_r[0] :
                        (chs_w == SASP_CH_RIGHT) ? rx_r[1] : sum_w[32:1];
    wire [31:0] mix_w = att_w ? {src_w[31], src_w[31:1]} : src_w;

    // ==========================================================
    // synchronisers; the link clocks are never driven here
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            bck_q <= 3'h0;
            wck_q <= 2'h0;
            sdi_q <= 2'h0;
            pll_ref_r <= 1'b0;
        end
        else
        begin
            bck_q <= {bck_q[1:0], link.bit_clock};
            wck_q <= {wck_q[0], link.word_clock};
            sdi_q <= {sdi_q[0], link.serial_data_in};
            pll_ref_r <= wck_w;
        end
    end

    // slot position and frame count, advanced on each rising bit clock
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            wck_prev_r <= 1'b0;
            pos_r <= 6'd0;
            slot_r <= 2'd0;
            frames_r <= 16'h0000;
        end
        else if (bck_rise)
        begin
            wck_prev_r <= wck_w;
            pos_r <= cur_pos;
            slot_r <= cur_slot;
            if (bound_w && cur_slot == 2'd0)
                frames_r <= 16'(frames_r + 16'd1);
        end
    end

    // receive shifter; only the two used slots are kept
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sh_r <= 32'h0000_0000;
            rx_r[0] <= 32'h0000_0000;
            rx_r[1] <= 32'h0000_0000;
            mix_go_r <= 1'b0;
        end
        else
        begin
            mix_go_r <= 1'b0;
            if (bck_rise && rx_bp[6])
            begin
                sh_r <= {sh_r[30:0], sdi_w};
                if (rx_last && !rx_slot[1])
                begin
                    rx_r[rx_slot[0]] <= rx_word;
                    mix_go_r <= rx_slot[0];
                end
            end
        end
    end

    // downstream sample, one pulse per frame after the second slot
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sample_r <= 32'h0000_0000;
            sample_valid_r <= 1'b0;
        end
        else
        begin
            sample_valid_r <= mix_go_r;
            if (mix_go_r)
                sample_r <= mix_w;
        end
    end

    // transmit pin, changed only on falling bit clocks
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sdo_r <= 1'b0;
            sdo_en_b_r <= 1'b1;
        end
        else if (bck_fall)
        begin
            sdo_r <= tx_used & tx_bit;
            sdo_en_b_r <= ~cfg_r[`SASP_TXEN_BIT] | (~tx_used & cfg_r[`SASP_HIZ_BIT]);
        end
    end

    // ==========================================================
    // ahb-lite: one wait state so that read data leaves a flop
    wire ahb_go = hsel_in & htrans_in[1] & hready_in;
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pend_r <= 1'b0;
            wr_r <= 1'b0;
            addr_r <= 8'h00;
            hreadyout_r <= 1'b1;
            hrdata_r <= 32'h0000_0000;
        end
        else if (ahb_go)
        begin
            pend_r <= 1'b1;
            wr_r <= hwrite_in;
            addr_r <= haddr_in[7:0];
            hreadyout_r <= 1'b0;
        end
        else if (pend_r)
        begin
            pend_r <= 1'b0;
            hreadyout_r <= 1'b1;
            hrdata_r <= wr_r ? 32'h0000_0000 : rd_w;
        end
    end

    // register writes; the rate field is kept for software to match the link
    wire wr_now = pend_r & wr_r;
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            ctrl_r <= `SASP_CTRL_RST;
            cfg_r <= `SASP_CFG_RST;
            tx_r[0] <= 32'h0000_0000;
            tx_r[1] <= 32'h0000_0000;
        end
        else if (wr_now)
        begin
            if (addr_r == `SASP_CTRL_OFS)
                ctrl_r <= hwdata_in[`SASP_CTRL_W-1:0];
            else if (addr_r == `SASP_CFG_OFS)
                cfg_r <= hwdata_in[1:0];
            else if (addr_r == `SASP_TXL_OFS)
                tx_r[0] <= hwdata_in;
            else if (addr_r == `SASP_TXR_OFS)
                tx_r[1] <= hwdata_in;
        end
    end

    // read decode; unmapped offsets read zero
    always_comb
    begin
        rd_w = 32'h0000_0000;
        if (addr_r == `SASP_CTRL_OFS)
            rd_w = 32'(ctrl_r);
        else if (addr_r == `SASP_CFG_OFS)
            rd_w = 32'(cfg_r);
        else if (addr_r == `SASP_RXL_OFS)
            rd_w = rx_r[0];
        else if (addr_r == `SASP_RXR_OFS)
            rd_w = rx_r[1];
        else if (addr_r == `SASP_TXL_OFS)
            rd_w = tx_r[0];
        else if (addr_r == `SASP_TXR_OFS)
            rd_w = tx_r[1];
        else if (addr_r == `SASP_OUT_OFS)
            rd_w = sample_r;
        else if (addr_r == `SASP_STAT_OFS)
            rd_w = 32'(frames_r);
    end

    // outputs
    assign hreadyout_out = hreadyout_r;
    assign hrdata_out = hrdata_r;
    assign hresp_out = 1'b0; // always okay
    assign sample_out = sample_r;
    assign sample_valid_out = sample_valid_r;
    assign pll_ref_out = pll_ref_r;
    assign link.serial_data_out = sdo_r;
    assign link.sdo_en_b = sdo_en_b_r;
endmodule : sasp_device

/* logic/sasp_host.sv */
// clock master end of the serial audio link
// assumes config inputs come from logic on mclk_in and change only while idle
`timescale 1ns/1ps
module sasp_host
    import sasp_pkg::*;
#(
    parameter int HALF_DIV = 6
)
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // serial link
    sasp_link_if.host link,
    // configuration
    input wire logic enable_in,
    input wire logic [1:0] format_in,
    input wire logic [1:0] width_sel_in,
    input wire logic [1:0] slot_len_sel_in,
    input wire logic tdm_in,
    // audio words, msb aligned
    input wire logic [31:0] tx_left_in,
    input wire logic [31:0] tx_right_in,
    output logic [31:0] rx_left_out,
    output logic [31:0] rx_right_out,
    output logic rx_valid_out
);
    // ==========================================================
    // registers
    logic [7:0] div_r;
    logic bck_r;
    logic wck_r;
    logic sdi_r;
    logic run_r;
    logic [5:0] pos_r;
    logic [1:0] slot_r;
    logic [5:0] ppos_r;
    logic [1:0] pslot_r;
    logic [1:0] sdo_q;
    logic [31:0] sh_r;
    logic [31:0] rx_r [2];
    logic valid_r;

    // ==========================================================
    // divider: this end makes both link clocks
    wire [5:0] wid_w = sasp_width(width_sel_in);
    wire [5:0] slen_w = sasp_slen(slot_len_sel_in);
    wire std_w = format_in == SASP_FMT_STD;
    wire tick = div_r == 8'(HALF_DIV - 1);
    wire fall_w = tick & bck_r;
    wire rise_w = tick & ~bck_r;

    // next position, counted bit clock by bit clock
    wire wrap_w = pos_r == 6'(slen_w - 6'd1);
    wire [1:0] last_w = tdm_in ? 2'd3 : 2'd1;
    wire [5:0] npos = (!run_r || wrap_w) ? 6'd0 : 6'(pos_r + 6'd1);
    wire [1:0] nslot = !run_r ? 2'd0 : !wrap_w ? slot_r :
                       (slot_r == last_w) ? 2'd0 : 2'(slot_r + 2'd1);
    wire nwck = tdm_in ? (nslot == 2'd0 && npos == 6'd0) : (std_w ? nslot[0] : ~nslot[0]);

    // drive side: standard lags one bit clock behind the word clock
    wire [5:0] dpos = std_w ? pos_r : npos;
    wire [1:0] dslot = std_w ? slot_r : nslot;
    wire [6:0] dbp = sasp_bit_pos(format_in, wid_w, slen_w, dpos);
    wire [31:0] dword = dslot[0] ? tx_right_in : tx_left_in;
    wire dbit = dbp[6] & ~dslot[1] & dword[5'(5'd31 - dbp[4:0])];

    // sample side uses what was driven at the last fall
    wire [5:0] spos = std_w ? ppos_r : pos_r;
    wire [1:0] sslot = std_w ? pslot_r : slot_r;
    wire [6:0] sbp = sasp_bit_pos(format_in, wid_w, slen_w, spos);
    wire slast = sbp[6] && (sbp[5:0] == 6'(wid_w - 6'd1));
    wire [31:0] sword = {sh_r[30:0], sdo_q[1]} << 6'(6'd32 - wid_w);

    // ==========================================================
    // clock generation and framing, changes made on falling edges
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            div_r <= 8'h00;
            bck_r <= 1'b0;
            wck_r <= 1'b0;
            sdi_r <= 1'b0;
            run_r <= 1'b0;
            pos_r <= 6'd0;
            slot_r <= 2'd0;
            ppos_r <= 6'd0;
            pslot_r <= 2'd0;
        end
        else if (!enable_in && !bck_r)
        begin
            div_r <= 8'h00;
            run_r <= 1'b0;
        end
        else
        begin
            div_r <= tick ? 8'h00 : 8'(div_r + 8'd1);
            if (tick)
                bck_r <= ~bck_r;
            if (fall_w)
            begin
                run_r <= 1'b1;
                ppos_r <= pos_r;
                pslot_r <= slot_r;
                pos_r <= npos;
                slot_r <= nslot;
                wck_r <= nwck;
                sdi_r <= dbit;
            end
        end
    end

    // return data: synchronised, shifted in on rising edges
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sdo_q <= 2'h0;
            sh_r <= 32'h0000_0000;
            rx_r[0] <= 32'h0000_0000;
            rx_r[1] <= 32'h0000_0000;
            valid_r <= 1'b0;
        end
        else
        begin
            sdo_q <= {sdo_q[0], link.serial_data_out & ~link.sdo_en_b};
            valid_r <= 1'b0;
            if (rise_w && run_r && sbp[6])
            begin
                sh_r <= {sh_r[30:0], sdo_q[1]};
                if (slast && !sslot[1])
                begin
                    rx_r[sslot[0]] <= sword;
                    valid_r <= sslot[0];
                end
            end
        end
    end

    // outputs
    assign link.bit_clock = bck_r;
    assign link.word_clock = wck_r;
    assign link.serial_data_in = sdi_r;
    assign rx_left_out = rx_r[0];
    assign rx_right_out = rx_r[1];
    assign rx_valid_out = valid_r;
endmodule : sasp_host

/* logic/sasp_link_if.sv */
// the four-wire serial audio link between the clock master and the device
// assumes the host end resolves the output pin from serial_data_out and sdo_en_b
`timescale 1ns/1ps
interface sasp_link_if;
    logic bit_clock;
    logic word_clock;
    logic serial_data_in;
    logic serial_data_out;
    logic sdo_en_b;
    // ==========================================================
    modport dev (input bit_clock, input word_clock, input serial_data_in,
                 output serial_data_out, output sdo_en_b);
    modport host (output bit_clock, output word_clock, output serial_data_in,
                  input serial_data_out, input sdo_en_b);
endinterface : sasp_link_if

/* logic/sasp_map.svh */
// register offsets, field positions and reset values of the audio serial port
// assumes inclusion by the device end and by the bench; definitions only
`ifndef SASP_MAP_SVH
`define SASP_MAP_SVH
// ==========================================================
// register byte offsets
`define SASP_CTRL_OFS 8'h00
`define SASP_CFG_OFS 8'h04
`define SASP_RXL_OFS 8'h08
`define SASP_RXR_OFS 8'h0C
`define SASP_TXL_OFS 8'h10
`define SASP_TXR_OFS 8'h14
`define SASP_OUT_OFS 8'h18
`define SASP_STAT_OFS 8'h1C
// ==========================================================
// audio_port_control fields
`define SASP_FMT_LSB 0
`define SASP_WID_LSB 2
`define SASP_RATE_LSB 4
`define SASP_SLEN_LSB 8
`define SASP_TDM_BIT 10
`define SASP_ATT_BIT 11
`define SASP_CHS_LSB 12
`define SASP_CTRL_W 14
// audio_port_config fields
`define SASP_TXEN_BIT 0
`define SASP_HIZ_BIT 1
// ==========================================================
// reset values
`define SASP_CTRL_RST 14'h0000
`define SASP_CFG_RST 2'h0
`endif

/* logic/sasp_pkg.sv */
// types and shared slot arithmetic of the audio serial port
// assumes nothing beyond a SystemVerilog compiler
package sasp_pkg;
    // ==========================================================
    // bit alignment formats and channel sources
    typedef enum logic [1:0] {SASP_FMT_STD, SASP_FMT_LEFT, SASP_FMT_RIGHT} sasp_format_type;
    typedef enum logic [1:0] {SASP_CH_LEFT, SASP_CH_RIGHT, SASP_CH_AVG} sasp_chan_type;

    // data width field to bits: 16, 20, 24, 32
    function automatic logic [5:0] sasp_width(input logic [1:0] sel);
        return (sel == 2'h0) ? 6'd16 : (sel == 2'h1) ? 6'd20 : (sel == 2'h2) ? 6'd24 : 6'd32;
    endfunction : sasp_width

    // slot length field to bit clocks: 16, 24, 32
    function automatic logic [5:0] sasp_slen(input logic [1:0] sel);
        return (sel == 2'h0) ? 6'd16 : (sel == 2'h1) ? 6'd24 : 6'd32;
    endfunction : sasp_slen

    // {active, msb-first bit index} for a bit position inside a slot
    function automatic logic [6:0] sasp_bit_pos(input logic [1:0] fmt, input logic [5:0] wid,
                                                input logic [5:0] slen, input logic [5:0] pos);
        logic [5:0] lead;
        logic [5:0] k;
        lead = (fmt == SASP_FMT_RIGHT) ? 6'(slen - wid) : 6'd0;
        k = 6'(pos - lead);
        return {(pos >= lead) && (k < wid), k};
    endfunction : sasp_bit_pos
endpackage : sasp_pkg
